// File: src/ams_seq.sv
// Asynchronous memory bus sequencer with AHB-Lite register port
`timescale 1ns/1ps
`default_nettype none
`include "ams_defs.svh"

// Notes on behaviour
// [RL1] Strobe low for programmed wait-state cycles
// [RL2] Address and select held for read hold
// [RL3] Read strobe one clock after address, select
// [RL4] Predictive same-bank read gap: hold, +1 if idle
// [RL5] Predictive other-bank read gap: hold plus idle
// [RL6] Read then write gap: hold plus max(idle,4)
// [RL7] Non-predictive same-bank read gap: hold plus 3
// [RL8] Non-predictive other-bank read: hold plus max(idle,3)
// [RL9] Idle count is idle cycles times clock
// [RL10] Write strobe and data one clock after select; the code drives data from the select clock
// [RL11] Write data valid one clock plus wait
// [RL12] Write hold keeps address, select, data driven
// [RL13] Data bus released one clock after hold
// [RL14] Write gaps: write 1+hold, read 3+hold
// [RL15] Data off two clocks before read strobe
// [RL16] Memory pulls ack low within read wait
// [RL17] Memory pulls ack low within write wait
// [RL18] Sequencing only in asynchronous access mode
// [RL19] Unused ack counts as high always
// [RL20] Low ack after wait extends strobe per clock
module ams_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Memory pins
    output logic [23:0] mem_addr,
    output logic [3:0] bank_select_n,
    output logic mem_read_strobe_n,
    output logic mem_write_strobe_n,
    input wire logic [31:0] mem_data_in,
    output logic [31:0] mem_data_out,
    output logic mem_data_oe,
    input wire logic mem_ack_in
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ams_pkg::ams_cfg_t cfg_q, cur_cfg_q;
    ams_pkg::ams_req_t pend_q, cur_q;
    ams_pkg::ams_state_t state_q, state_d;
    logic [31:0] ctrl_q, addr_reg_q, wdata_reg_q, rdata_q, hrdata_q;
    logic pend_vld_q, rdone_q, ackext_q;
    logic wr_ph_q;
    logic [31:0] wr_addr_q;
    logic [4:0] cnt_q, cnt_d, since_q, since_d, need, wait_eff, hold_n;
    logic [4:0] idle_x;
    logic start, strobe_done, hold_done, ack_low, active_d, rd_capture;
    logic ack_s1_q, ack_s2_q;
    logic [31:0] din_s1_q, din_s2_q;
    logic [23:0] mem_addr_q;
    logic [3:0] sel_n_q;
    logic rd_n_q, wr_n_q, oe_q;
    logic [31:0] dout_q;
    logic hreadyout_q, hresp_q;
    logic addr_ph, cmd_wr;
    logic [31:0] rd_mux;
    logic [7:0] low_cnt_q;
    ams_pkg::ams_req_t nx;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    assign addr_ph = hsel && hready && (htrans == `AMS_HTRANS_NONSEQ) &&
                     (hsize == `AMS_HSIZE_WORD);
    assign cmd_wr = wr_ph_q && (wr_addr_q == `AMS_REG_CMD);

    always_comb begin
        rd_mux = 32'h00000000;
        if (haddr == `AMS_REG_CTRL) begin
            rd_mux = ctrl_q;
        end else if (haddr == `AMS_REG_ADDR) begin
            rd_mux = addr_reg_q;
        end else if (haddr == `AMS_REG_WDATA) begin
            rd_mux = wdata_reg_q;
        end else if (haddr == `AMS_REG_RDATA) begin
            rd_mux = rdata_q;
        end else if (haddr == `AMS_REG_STATUS) begin
            rd_mux[`AMS_ST_BUSY] = (state_q != ams_pkg::AMS_IDLE);
            rd_mux[`AMS_ST_PEND] = pend_vld_q;
            rd_mux[`AMS_ST_RDONE] = rdone_q;
            rd_mux[`AMS_ST_ACKEXT] = ackext_q;
        end
    end

    // Address phase capture, read data ready for the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ph_q <= 1'b0;
            wr_addr_q <= 32'h00000000;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b0;
            hresp_q <= 1'b0;
        end else begin
            wr_ph_q <= addr_ph && hwrite;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            if (addr_ph) begin
                wr_addr_q <= haddr;
            end
            if (addr_ph && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Writable registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `AMS_CTRL_RST;
            addr_reg_q <= 32'h00000000;
            wdata_reg_q <= 32'h00000000;
        end else if (wr_ph_q) begin
            if (wr_addr_q == `AMS_REG_CTRL) begin
                ctrl_q <= hwdata;
            end
            if (wr_addr_q == `AMS_REG_ADDR) begin
                addr_reg_q <= hwdata;
            end
            if (wr_addr_q == `AMS_REG_WDATA) begin
                wdata_reg_q <= hwdata;
            end
        end
    end

    always_comb begin
        cfg_q.wait_st = ctrl_q[`AMS_CTRL_WAIT];
        cfg_q.hold = ctrl_q[`AMS_CTRL_HOLD];
        cfg_q.read_hold_cycles = ctrl_q[`AMS_CTRL_RHC];
        cfg_q.idle = ctrl_q[`AMS_CTRL_IDLE];
        cfg_q.predictive_read_disable = ctrl_q[`AMS_CTRL_PREDICTIVE_READ_DISABLE];
        cfg_q.ack_en = ctrl_q[`AMS_CTRL_ACKEN];
        cfg_q.async_en = ctrl_q[`AMS_CTRL_ASYNC];
    end

    // One queued command; a command while one waits is dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_vld_q <= 1'b0;
            pend_q <= '0;
        end else if (cmd_wr && !pend_vld_q) begin
            pend_vld_q <= 1'b1;
            pend_q.wr <= hwdata[`AMS_CMD_WRITE];
            pend_q.bank <= addr_reg_q[`AMS_ADDR_BANK];
            pend_q.addr <= addr_reg_q[`AMS_ADDR_MEM];
            pend_q.wdata <= wdata_reg_q;
        end else if (start) begin
            pend_vld_q <= 1'b0;
        end
    end

    // Sticky status; a new event wins over the clearing command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdone_q <= 1'b0;
            ackext_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            if (rd_capture) begin
                rdone_q <= 1'b1;
                rdata_q <= din_s2_q;
            end else if (cmd_wr) begin
                rdone_q <= 1'b0;
            end
            if (state_q == ams_pkg::AMS_STROBE && cnt_q == 5'h00 && ack_low) begin
                ackext_q <= 1'b1;
            end else if (cmd_wr) begin
                ackext_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b1;
            ack_s2_q <= 1'b1;
            din_s1_q <= 32'h00000000;
            din_s2_q <= 32'h00000000;
        end else begin
            ack_s1_q <= mem_ack_in;
            ack_s2_q <= ack_s1_q;
            din_s1_q <= mem_data_in;
            din_s2_q <= din_s1_q;
        end
    end

    assign ack_low = cur_cfg_q.ack_en && !ack_s2_q; // [RL19] [RL20]

    // ----------------------------------------------------------------
    // Turnaround gap
    // ----------------------------------------------------------------
    assign idle_x = {1'b0, cfg_q.idle}; // [RL9]

    always_comb begin
        need = `AMS_WR2WR_GAP;
        if (cur_q.wr) begin
            need = pend_q.wr ? `AMS_WR2WR_GAP : `AMS_WR2RD_GAP; // [RL14]
        end else if (pend_q.wr) begin
            need = (idle_x > `AMS_RD2WR_MIN) ? idle_x : `AMS_RD2WR_MIN; // [RL6]
        end else if (cfg_q.predictive_read_disable) begin
            if (pend_q.bank == cur_q.bank) begin
                need = `AMS_RD2RD_NOPRED; // [RL7]
            end else begin
                need = (idle_x > `AMS_RD2RD_NOPRED) ? idle_x : `AMS_RD2RD_NOPRED; // [RL8]
            end
        end else if (pend_q.bank == cur_q.bank) begin
            need = (idle_x == 5'h00) ? 5'h00 : 5'h01; // [RL4]
        end else begin
            need = idle_x; // [RL5]
        end
    end

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    assign wait_eff = (cur_cfg_q.wait_st == 5'h00) ? 5'h01 : cur_cfg_q.wait_st;
    assign hold_n = cur_q.wr ? {2'b00, cur_cfg_q.hold} : {2'b00, cur_cfg_q.read_hold_cycles};

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        since_d = (since_q == `AMS_SINCE_MAX) ? since_q : since_q + 5'h01;
        start = 1'b0;
        strobe_done = 1'b0;
        hold_done = 1'b0;
        unique case (state_q)
            ams_pkg::AMS_IDLE: begin
                if (pend_vld_q && cfg_q.async_en && (since_q + 5'h01 >= need)) begin // [RL18]
                    state_d = ams_pkg::AMS_SETUP;
                    start = 1'b1;
                end
            end
            ams_pkg::AMS_SETUP: begin
                state_d = ams_pkg::AMS_STROBE; // [RL3] [RL10]
                cnt_d = wait_eff - 5'h01; // [RL1]
            end
            ams_pkg::AMS_STROBE: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - 5'h01; // [RL1]
                end else if (!ack_low) begin // [RL20]
                    strobe_done = 1'b1;
                end
            end
            ams_pkg::AMS_HOLD: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - 5'h01; // [RL2] [RL12]
                end else begin
                    hold_done = 1'b1;
                end
            end
        endcase
        if (strobe_done && hold_n != 5'h00) begin
            state_d = ams_pkg::AMS_HOLD;
            cnt_d = hold_n - 5'h01;
        end
        if ((strobe_done && hold_n == 5'h00) || hold_done) begin
            since_d = 5'h00;
            if (pend_vld_q && cfg_q.async_en && need == 5'h00) begin
                state_d = ams_pkg::AMS_SETUP;
                start = 1'b1;
            end else begin
                state_d = ams_pkg::AMS_IDLE;
            end
        end
    end

    assign rd_capture = strobe_done && !cur_q.wr;
    assign nx = start ? pend_q : cur_q;
    assign active_d = (state_d != ams_pkg::AMS_IDLE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ams_pkg::AMS_IDLE;
            cnt_q <= 5'h00;
            since_q <= `AMS_SINCE_MAX;
            cur_q <= '0;
            cur_cfg_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            since_q <= since_d;
            if (start) begin
                cur_q <= pend_q;
                cur_cfg_q <= cfg_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr_q <= 24'h000000;
            sel_n_q <= `AMS_SEL_NONE;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            oe_q <= 1'b0;
            dout_q <= 32'h00000000;
        end else begin
            if (start) begin
                mem_addr_q <= pend_q.addr;
                dout_q <= pend_q.wdata; // [RL11]
            end
            sel_n_q <= active_d ? ~(4'h1 << nx.bank) : `AMS_SEL_NONE; // [RL2] [RL12]
            rd_n_q <= !((state_d == ams_pkg::AMS_STROBE) && !nx.wr); // [RL1] [RL3]
            wr_n_q <= !((state_d == ams_pkg::AMS_STROBE) && nx.wr); // [RL10]
            // One extra cycle of drive once the write hold ends
            oe_q <= (active_d && nx.wr) || (hold_done && cur_q.wr) ||
                    (strobe_done && hold_n == 5'h00 && cur_q.wr); // [RL13] [RL15]
        end
    end

    assign mem_addr = mem_addr_q;
    assign bank_select_n = sel_n_q;
    assign mem_read_strobe_n = rd_n_q;
    assign mem_write_strobe_n = wr_n_q;
    assign mem_data_out = dout_q;
    assign mem_data_oe = oe_q;
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_q <= 8'h00;
        end else if (!rd_n_q || !wr_n_q) begin
            low_cnt_q <= (low_cnt_q == `AMS_LOWCNT_MAX) ? low_cnt_q : low_cnt_q + 8'h01;
        end else begin
            low_cnt_q <= 8'h00;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd_setup;
        rd_n_q && wr_n_q && (sel_n_q != `AMS_SEL_NONE);
    endsequence
    sequence s_rd_strobe;
        !rd_n_q && $stable(sel_n_q) && $stable(mem_addr_q);
    endsequence

    property p_rd_setup;
        (state_q == ams_pkg::AMS_SETUP && !cur_q.wr) |-> s_rd_setup ##1 s_rd_strobe;
    endproperty
    a_rd_setup: assert property (p_rd_setup) else $error("read strobe not one clock after select"); // [RL3]

    property p_wait_min;
        ($rose(rd_n_q) || $rose(wr_n_q)) |-> low_cnt_q >= {3'h0, wait_eff};
    endproperty
    a_wait_min: assert property (p_wait_min) else $error("strobe shorter than wait states"); // [RL1]

    property p_no_ack_exact;
        (($rose(rd_n_q) || $rose(wr_n_q)) && !cur_cfg_q.ack_en) |-> low_cnt_q == {3'h0, wait_eff};
    endproperty
    a_no_ack_exact: assert property (p_no_ack_exact) else $error("strobe length not set by wait"); // [RL19]

    property p_ack_extend;
        (state_q == ams_pkg::AMS_STROBE && cnt_q == 5'h00 && ack_low) |=>
            (state_q == ams_pkg::AMS_STROBE) && !(rd_n_q && wr_n_q);
    endproperty
    a_ack_extend: assert property (p_ack_extend) else $error("low ack did not extend strobe"); // [RL20]

    property p_hold_stable;
        (state_q == ams_pkg::AMS_HOLD) |->
            $stable(mem_addr_q) && $stable(sel_n_q) && (sel_n_q != `AMS_SEL_NONE);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("address moved during hold"); // [RL2]

    property p_wr_start;
        $fell(wr_n_q) |-> oe_q && $past(oe_q) && ($past(sel_n_q) != `AMS_SEL_NONE);
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write data not driven at setup"); // [RL10]

    property p_wr_data_hold;
        (state_q == ams_pkg::AMS_HOLD && cur_q.wr) |-> oe_q && $stable(dout_q);
    endproperty
    a_wr_data_hold: assert property (p_wr_data_hold) else $error("write data lost in hold"); // [RL12]

    property p_release;
        (hold_done && cur_q.wr && state_d == ams_pkg::AMS_IDLE) |=>
            oe_q ##1 (!oe_q || state_q == ams_pkg::AMS_SETUP);
    endproperty
    a_release: assert property (p_release) else $error("data bus release off by a clock"); // [RL13]

    property p_turn_off;
        $fell(rd_n_q) |-> !oe_q && !$past(oe_q) && !$past(oe_q, 2);
    endproperty
    a_turn_off: assert property (p_turn_off) else $error("data driven too near read strobe"); // [RL15]

    property p_async_only;
        (state_q == ams_pkg::AMS_IDLE && !cfg_q.async_en) |=> state_q == ams_pkg::AMS_IDLE;
    endproperty
    a_async_only: assert property (p_async_only) else $error("access outside async mode"); // [RL18]

endmodule
`default_nettype wire

// File: include/ams_defs.svh
// Constants of the asynchronous memory bus sequencer
`ifndef AMS_DEFS_SVH
`define AMS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define AMS_REG_CTRL 32'h00000000
`define AMS_REG_ADDR 32'h00000004
`define AMS_REG_WDATA 32'h00000008
`define AMS_REG_CMD 32'h0000000C
`define AMS_REG_RDATA 32'h00000010
`define AMS_REG_STATUS 32'h00000014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AMS_CTRL_WAIT 4:0
`define AMS_CTRL_HOLD 10:8
`define AMS_CTRL_RHC 14:12
`define AMS_CTRL_IDLE 19:16
`define AMS_CTRL_PREDICTIVE_READ_DISABLE 24
`define AMS_CTRL_ACKEN 25
`define AMS_CTRL_ASYNC 26
`define AMS_ADDR_MEM 23:0
`define AMS_ADDR_BANK 29:28
`define AMS_CMD_WRITE 0
`define AMS_ST_BUSY 0
`define AMS_ST_PEND 1
`define AMS_ST_RDONE 2
`define AMS_ST_ACKEXT 3

// ----------------------------------------------------------------
// Reset values and bus codes
// ----------------------------------------------------------------
`define AMS_CTRL_RST 32'h04000001
`define AMS_HTRANS_NONSEQ 2'h2
`define AMS_HSIZE_WORD 3'h2
`define AMS_SEL_NONE 4'hF

// ----------------------------------------------------------------
// Turnaround gaps in clock periods
// ----------------------------------------------------------------
`define AMS_RD2WR_MIN 5'h04
`define AMS_RD2RD_NOPRED 5'h03
`define AMS_WR2RD_GAP 5'h02
`define AMS_WR2WR_GAP 5'h00
// Saturates one below the top so since plus one cannot wrap
`define AMS_SINCE_MAX 5'h1E
`define AMS_LOWCNT_MAX 8'hFF

`endif

// File: include/ams_pkg.sv
// Types of the asynchronous memory bus sequencer
`include "ams_defs.svh"

package ams_pkg;

    typedef enum logic [1:0] {
        AMS_IDLE = 2'b00,
        AMS_SETUP = 2'b01,
        AMS_STROBE = 2'b10,
        AMS_HOLD = 2'b11
    } ams_state_t;

    typedef struct packed {
        logic async_en;
        logic ack_en;
        logic predictive_read_disable;
        logic [3:0] idle;
        logic [2:0] read_hold_cycles;
        logic [2:0] hold;
        logic [4:0] wait_st;
    } ams_cfg_t;

    typedef struct packed {
        logic wr;
        logic [1:0] bank;
        logic [23:0] addr;
        logic [31:0] wdata;
    } ams_req_t;

endpackage

// File: test/ams_sram_model.sv
// Behavioural asynchronous static memory on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module ams_sram_model (
    // Clock
    input wire logic clk,
    // Memory pins
    input wire logic [23:0] mem_addr,
    input wire logic [3:0] bank_select_n,
    input wire logic mem_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic [31:0] mem_data_out,
    input wire logic mem_data_oe,
    output logic [31:0] mem_data_in,
    output logic mem_ack_in,
    // Ack low length per strobe
    input wire logic [3:0] ack_len
);
    logic [31:0] mem [256];
    logic [31:0] last_q;
    logic [3:0] lo_q;
    logic rd_on;
    logic str_on;

    assign str_on = !(mem_read_strobe_n && mem_write_strobe_n) && (bank_select_n != 4'hF);
    assign rd_on = !mem_read_strobe_n && (bank_select_n != 4'hF);
    // Released bus shows the inverse of the last value
    assign mem_data_in = rd_on ? mem[mem_addr[7:0]] : ~last_q;
    // Ack pulled low from strobe fall, well inside the wait time
    assign mem_ack_in = !(str_on && (lo_q < ack_len));

    always @(posedge clk) begin
        if (!mem_write_strobe_n && mem_data_oe) begin
            mem[mem_addr[7:0]] <= mem_data_out;
        end
        if (rd_on) begin
            last_q <= mem[mem_addr[7:0]];
        end
        if (!str_on) begin
            lo_q <= 4'h0;
        end else if (lo_q != 4'hF) begin
            lo_q <= lo_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: test/ams_seq_bench.sv
// Self-checking bench of the memory bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ams_defs.svh"
module ams_seq_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, mem_data_in, mem_data_out, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, mem_read_strobe_n, mem_write_strobe_n, mem_data_oe, mem_ack_in;
    logic [23:0] mem_addr;
    logic [3:0] bank_select_n, ack_len;
    logic sel_p, str_p, oe_p;
    logic [7:0] tbl [10];
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int i;
    int t_sf, t_lo, t_hi, t_oe, setup, gap, width, hold_c, oe_tail, oe_gap, n_acc;
    wire logic str_n = mem_read_strobe_n & mem_write_strobe_n;
    wire logic sel_n = &bank_select_n;

    always #50 clk = ~clk;

    ams_seq i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mem_addr(mem_addr),
        .bank_select_n(bank_select_n), .mem_read_strobe_n(mem_read_strobe_n),
        .mem_write_strobe_n(mem_write_strobe_n), .mem_data_in(mem_data_in),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_ack_in(mem_ack_in));

    ams_sram_model i_mem (.clk(clk), .mem_addr(mem_addr), .bank_select_n(bank_select_n),
        .mem_read_strobe_n(mem_read_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in),
        .mem_ack_in(mem_ack_in), .ack_len(ack_len));

    // ----------------------------------------------------------------
    // Pin monitor: cycle distances between edges
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (sel_p && !sel_n) t_sf = cyc;
        if (str_p && !str_n) begin
            setup = cyc - t_sf;
            gap = cyc - t_hi;
            oe_gap = cyc - t_oe;
            t_lo = cyc;
            n_acc++;
        end
        if (!str_p && str_n) begin
            width = cyc - t_lo;
            t_hi = cyc;
        end
        if (!sel_p && sel_n) hold_c = cyc - t_hi;
        if (oe_p && !mem_data_oe) begin
            oe_tail = cyc - t_hi;
            t_oe = cyc;
        end
        sel_p = sel_n;
        str_p = str_n;
        oe_p = mem_data_oe;
        if (cyc > 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        haddr <= a;
        hwrite <= wr;
        htrans <= `AMS_HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_st(input logic [31:0] mask);
        do begin
            ahb(1'b0, `AMS_REG_STATUS, 32'h0);
        end while ((rd & mask) !== 32'h0);
    endtask

    task automatic access(input logic wr, input logic [1:0] bk, input logic [23:0] a,
        input logic [31:0] d);
        ahb(1'b1, `AMS_REG_ADDR, {2'h0, bk, 4'h0, a});
        ahb(1'b1, `AMS_REG_WDATA, d);
        ahb(1'b1, `AMS_REG_CMD, {31'h0, wr});
    endtask

    function automatic logic [31:0] ctl(input logic [4:0] w, input logic [2:0] h,
        input logic [2:0] r, input logic [3:0] ic, input logic pd, input logic ak, input logic en);
        ctl = 32'h0;
        ctl[`AMS_CTRL_WAIT] = w;
        ctl[`AMS_CTRL_HOLD] = h;
        ctl[`AMS_CTRL_RHC] = r;
        ctl[`AMS_CTRL_IDLE] = ic;
        ctl[`AMS_CTRL_PREDICTIVE_READ_DISABLE] = pd;
        ctl[`AMS_CTRL_ACKEN] = ak;
        ctl[`AMS_CTRL_ASYNC] = en;
    endfunction

    // Entry {first wr, second wr, same bank, predictive_read_disable, idle}; hold 1, read hold 2
    function automatic int exp_gap(input logic [7:0] e);
        int ic;
        int g;
        ic = e[3:0];
        if (e[7]) g = e[6] ? 0 : 2;
        else if (e[6]) g = (ic > 4) ? ic : 4;
        else if (e[4]) g = e[5] ? 3 : ((ic > 3) ? ic : 3);
        else g = e[5] ? ((ic == 0) ? 0 : 1) : ic;
        exp_gap = (e[7] ? 1 : 2) + g + 1;
    endfunction

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        hsel <= 1'b1;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= `AMS_HSIZE_WORD;
        hwdata <= 32'h0;
        ack_len <= 4'h0;
        tbl = '{8'hE0, 8'h80, 8'h62, 8'h46, 8'h20, 8'h23, 8'h05, 8'h30, 8'h11, 8'h16};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ahb(1'b0, `AMS_REG_CTRL, 32'h0);
        check(rd, `AMS_CTRL_RST);
        check(32'(hresp), 32'h0);
        ahb(1'b1, 32'h00000018, 32'hFFFFFFFF);
        ahb(1'b0, 32'h00000018, 32'h0);
        check(rd, 32'h0);
        // Single write then read back, wait 3, hold 2, read hold 1
        ahb(1'b1, `AMS_REG_CTRL, ctl(5'h03, 3'h2, 3'h1, 4'h0, 1'b0, 1'b0, 1'b1));
        access(1'b1, 2'h1, 24'h000123, 32'hA5A51234);
        wait_st(32'h3);
        check(setup, 1);
        check(width, 3);
        check(hold_c, 2);
        check(oe_tail, 3);
        check(i_mem.mem[8'h23], 32'hA5A51234);
        access(1'b0, 2'h1, 24'h000123, 32'h0);
        wait_st(32'h3);
        check(setup, 1);
        check(width, 3);
        check(hold_c, 1);
        check(32'(oe_gap >= 2), 1);
        ahb(1'b0, `AMS_REG_RDATA, 32'h0);
        check(rd, 32'hA5A51234);
        ahb(1'b0, `AMS_REG_STATUS, 32'h0);
        check(rd[`AMS_ST_RDONE], 1'b1);
        // Turnaround gaps between queued pairs
        for (int i = 0; i < 10; i++) begin
            ahb(1'b1, `AMS_REG_CTRL, ctl(5'h14, 3'h1, 3'h2, tbl[i][3:0], tbl[i][4], 1'b0, 1'b1));
            access(tbl[i][7], 2'h0, 24'h000010, 32'h11110000);
            wait_st(32'h2);
            access(tbl[i][6], tbl[i][5] ? 2'h0 : 2'h2, 24'h000011, 32'h22220000);
            wait_st(32'h3);
            check(gap, exp_gap(tbl[i]));
        end
        // Ack low after the wait stretches the strobe
        ack_len <= 4'h6;
        // Wait 3 so the two-flop synced ack is seen at expiry
        ahb(1'b1, `AMS_REG_CTRL, ctl(5'h03, 3'h0, 3'h0, 4'h0, 1'b0, 1'b1, 1'b1));
        access(1'b0, 2'h0, 24'h000023, 32'h0);
        wait_st(32'h3);
        check(width, 9);
        ahb(1'b0, `AMS_REG_STATUS, 32'h0);
        check(rd[`AMS_ST_ACKEXT], 1'b1);
        ahb(1'b1, `AMS_REG_CTRL, ctl(5'h02, 3'h0, 3'h0, 4'h0, 1'b0, 1'b0, 1'b1));
        access(1'b0, 2'h0, 24'h000023, 32'h0);
        wait_st(32'h3);
        check(width, 2);
        ack_len <= 4'h0;
        // No access while asynchronous mode is off
        ahb(1'b1, `AMS_REG_CTRL, ctl(5'h02, 3'h0, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0));
        i = n_acc;
        access(1'b0, 2'h3, 24'h000023, 32'h0);
        repeat (20) @(posedge clk);
        ahb(1'b0, `AMS_REG_STATUS, 32'h0);
        check(rd[1:0], 2'b10);
        check(n_acc, i);
        ahb(1'b1, `AMS_REG_CTRL, ctl(5'h02, 3'h0, 3'h0, 4'h0, 1'b0, 1'b0, 1'b1));
        wait_st(32'h3);
        check(n_acc, i + 1);
        wrap_up();
    end
endmodule
`default_nettype wire
